// ===== core/jtag_cfg.svh
// Constants of the test-access port: opcodes, reset patterns, boundary cell layout
// and the offsets of the bus-visible registers.
// Included by the package and by every module of the port; holds definitions only.
`ifndef JTAG_CFG_SVH
`define JTAG_CFG_SVH

// ****************************************************************
// Instruction register patterns
// ****************************************************************
`define IR_INIT 8'hEF
`define IR_LOW 8'hFD
`define IR_CAPTURE 8'h01

// ****************************************************************
// Opcodes in the upper four instruction bits; debug request in the upper three
// ****************************************************************
`define OP_EXTEST 4'h0
`define OP_CLAMP 4'h2
`define OP_HIGHZ 4'h3
`define OP_SAMPLE 4'h4
`define OP_RST_NEGATE 4'h6
`define OP_RST_ASSERT 4'h7
`define OP_IDCODE 4'hE
`define OP_BYPASS 4'hF
`define OP_DEBUG_REQ 3'h5

// ****************************************************************
// Boundary chain layout
// ****************************************************************
`define BS_LEN 333
`define BS_PINS 111
`define BS_IN_LSB 222
`define BS_OUT_LSB 111
`define BS_CTL_LSB 0

// ****************************************************************
// Register offsets, fields and responses
// ****************************************************************
`define AXI_AW 8
`define OFF_INSTR 8'h00
`define OFF_CTRL 8'h04
`define OFF_STATUS 8'h08
`define CTRL_DBG_CLR 0
`define STAT_DBG 4
`define STAT_RST 5
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ===== core/jtag_pkg.sv
// Types of the test-access port: controller states, data register choice and
// the packed state records of both modules.
// Assumes the constants header is on the include path.
`include "jtag_cfg.svh"
package jtag_pkg;

    // ****************************************************************
    // Controller states, numbered in 4-bit Gray code order from TLR to UPD_IR
    // ****************************************************************
    typedef enum logic [3:0] {
        TLR = 4'h0, IDLE = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
        SHIFT_DR = 4'h6, EX1_DR = 4'h7, PAUSE_DR = 4'h5, EX2_DR = 4'h4,
        UPD_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF, SHIFT_IR = 4'hE,
        EX1_IR = 4'hA, PAUSE_IR = 4'hB, EX2_IR = 4'h9, UPD_IR = 4'h8
    } tap_state_t;

    typedef enum logic [1:0] {
        DR_BYP = 2'h0, DR_ID = 2'h1, DR_BSC = 2'h2
    } dr_sel_t;

    // ****************************************************************
    // State records
    // ****************************************************************
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic tck_d;
        tap_state_t st;
        logic [7:0] ir;
        logic [7:0] ir_sh;
        logic byp;
        logic [31:0] id_sh;
        logic tdo;
        logic tdo_oe_n;
        logic dbg_req;
        logic int_rst;
        logic awready;
        logic wready;
        logic aw_ok;
        logic w_ok;
        logic [`AXI_AW-1:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } tap_s_t;

    typedef struct packed {
        logic [`BS_LEN-1:0] sh;
        logic [`BS_LEN-1:0] upd;
        logic [`BS_PINS-1:0] p1;
        logic [`BS_PINS-1:0] p2;
        logic [`BS_PINS-1:0] pad_out;
        logic [`BS_PINS-1:0] pad_oe_n;
        logic [`BS_PINS-1:0] core_in;
    } chain_s_t;

endpackage: jtag_pkg

// ===== core/pin_chain.sv
// Boundary cell chain at the pads: shift stages, update latches and pad muxes.
// Assumes capture, shift and update pulses come from the port logic on clk,
// and that pad inputs arrive from outside the clock domain.
`timescale 1ns/1ps
`include "jtag_cfg.svh"
module pin_chain
    import jtag_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic cap,
    input logic shf,
    input logic upd,
    input logic tdi_bit,
    input logic drive,
    input logic highz,
    input logic [`BS_PINS-1:0] core_out,
    input logic [`BS_PINS-1:0] core_oe,
    input logic [`BS_PINS-1:0] pad_in,
    output logic [`BS_PINS-1:0] pad_out,
    output logic [`BS_PINS-1:0] pad_oe_n,
    output logic [`BS_PINS-1:0] core_in,
    output logic scan_lsb
);

    chain_s_t r;
    chain_s_t n;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Chain and update cells are never reset, their content is undefined.
    always_comb begin
        n = r;
        n.p1 = pad_in;
        n.p2 = r.p1;
        if (cap) begin
            n.sh = {r.p2, r.pad_out, ~r.pad_oe_n};
        end else if (shf) begin
            n.sh = {tdi_bit, r.sh[`BS_LEN-1:1]};
        end
        if (upd) begin
            n.upd = r.sh;
        end
        // Test modes take the pads away from the core; high impedance wins.
        if (highz) begin
            n.pad_out = r.upd[`BS_OUT_LSB +: `BS_PINS];
            n.pad_oe_n = '1;
        end else if (drive) begin
            n.pad_out = r.upd[`BS_OUT_LSB +: `BS_PINS];
            n.pad_oe_n = ~r.upd[`BS_CTL_LSB +: `BS_PINS];
        end else begin
            n.pad_out = core_out;
            n.pad_oe_n = ~core_oe;
        end
        n.core_in = drive ? r.upd[`BS_IN_LSB +: `BS_PINS] : r.p2;
        if (reset) begin
            n.pad_out = '0;
            n.pad_oe_n = '1;
            n.core_in = '0;
        end
    end

    // Single register of the whole state record.
    always_ff @(posedge clk) begin
        r <= n;
    end

    assign pad_out = r.pad_out;
    assign pad_oe_n = r.pad_oe_n;
    assign core_in = r.core_in;
    assign scan_lsb = r.sh[0];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_highz_float;
        highz |=> (&r.pad_oe_n);
    endproperty
    a_highz_float: assert property (p_highz_float)
        else $error("pads still driven under high impedance mode");

    property p_tdi_end;
        shf && !cap |=> (r.sh[`BS_LEN-1] == $past(tdi_bit)) && (r.sh[0] == $past(r.sh[1]));
    endproperty
    a_tdi_end: assert property (p_tdi_end)
        else $error("chain did not shift toward the low cell");

endmodule: pin_chain

// ===== core/tap_scan.sv
// Test-access port data and instruction registers with their bus view.
// Assumes the tester pins arrive asynchronously and are sampled on clk;
// TCK must be far slower than clk (at least eight clk periods per TCK period).
`timescale 1ns/1ps
`include "jtag_cfg.svh"
module tap_scan
    import jtag_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0ACE_0001 // Arbitrary identity; bit 0 kept one.
) (
    input logic clk,
    input logic reset,
    input logic tck,
    input logic tms,
    input logic tdi,
    input logic trst_n,
    output logic tdo,
    output logic tdo_oe_n,
    output logic debug_req,
    output logic core_reset_req,
    input logic [`BS_PINS-1:0] core_out,
    input logic [`BS_PINS-1:0] core_oe,
    input logic [`BS_PINS-1:0] pad_in,
    output logic [`BS_PINS-1:0] pad_out,
    output logic [`BS_PINS-1:0] pad_oe_n,
    output logic [`BS_PINS-1:0] core_in,
    input logic [`AXI_AW-1:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [`AXI_AW-1:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready
);

    tap_s_t r;
    tap_s_t n;
    logic rise;
    logic fall;
    logic trst_l;
    logic bs_cap;
    logic bs_shf;
    logic bs_upd;
    logic bs_drive;
    logic bs_highz;
    logic bs_lsb;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // Standard controller walk on one TCK rising edge.
    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        tap_state_t t;
        t = s;
        unique case (s)
            TLR: t = m ? TLR : IDLE;
            IDLE: t = m ? SEL_DR : IDLE;
            SEL_DR: t = m ? SEL_IR : CAP_DR;
            CAP_DR: t = m ? EX1_DR : SHIFT_DR;
            SHIFT_DR: t = m ? EX1_DR : SHIFT_DR;
            EX1_DR: t = m ? UPD_DR : PAUSE_DR;
            PAUSE_DR: t = m ? EX2_DR : PAUSE_DR;
            EX2_DR: t = m ? UPD_DR : SHIFT_DR;
            UPD_DR: t = m ? SEL_DR : IDLE;
            SEL_IR: t = m ? TLR : CAP_IR;
            CAP_IR: t = m ? EX1_IR : SHIFT_IR;
            SHIFT_IR: t = m ? EX1_IR : SHIFT_IR;
            EX1_IR: t = m ? UPD_IR : PAUSE_IR;
            PAUSE_IR: t = m ? EX2_IR : PAUSE_IR;
            EX2_IR: t = m ? UPD_IR : SHIFT_IR;
            UPD_IR: t = m ? SEL_DR : IDLE;
        endcase
        return t;
    endfunction: tap_next

    // Reserved opcodes fall back to bypass so a stray load cannot hang the chain.
    function automatic dr_sel_t dr_of(input logic [7:0] code);
        dr_sel_t d;
        d = DR_BYP;
        if (code[7:4] == `OP_IDCODE) begin
            d = DR_ID;
        end else if (code[7:4] == `OP_EXTEST || code[7:4] == `OP_SAMPLE) begin
            d = DR_BSC;
        end
        return d;
    endfunction: dr_of

    // ****************************************************************
    // Pin sampling and boundary control
    // ****************************************************************
    // Edges are found only on the second synchroniser stage.
    assign rise = r.s2[2] & ~r.tck_d;
    assign fall = ~r.s2[2] & r.tck_d;
    assign trst_l = ~r.s2[3];
    assign bs_cap = rise && r.st == CAP_DR && dr_of(r.ir) == DR_BSC;
    assign bs_shf = rise && r.st == SHIFT_DR && dr_of(r.ir) == DR_BSC;
    assign bs_upd = fall && r.st == UPD_DR && dr_of(r.ir) == DR_BSC;
    assign bs_drive = r.ir[7:4] == `OP_EXTEST || r.ir[7:4] == `OP_CLAMP;
    assign bs_highz = r.ir[7:4] == `OP_HIGHZ;

    pin_chain u_chain (
        .clk(clk),
        .reset(reset),
        .cap(bs_cap),
        .shf(bs_shf),
        .upd(bs_upd),
        .tdi_bit(r.s2[0]),
        .drive(bs_drive),
        .highz(bs_highz),
        .core_out(core_out),
        .core_oe(core_oe),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe_n(pad_oe_n),
        .core_in(core_in),
        .scan_lsb(bs_lsb)
    );

    // ****************************************************************
    // Next state of port and bus slave
    // ****************************************************************
    always_comb begin
        n = r;
        n.s1 = {trst_n, tck, tms, tdi};
        n.s2 = r.s1;
        n.tck_d = r.s2[2];
        // Shift paths move on TCK rising; the walk follows TMS.
        if (rise) begin
            n.st = tap_next(r.st, r.s2[1]);
            unique case (r.st)
                CAP_DR: begin
                    n.byp = 1'b0;
                    n.id_sh = ID_VALUE;
                end
                SHIFT_DR: begin
                    n.byp = r.s2[0];
                    n.id_sh = {r.s2[0], r.id_sh[31:1]};
                end
                CAP_IR: n.ir_sh = `IR_CAPTURE;
                SHIFT_IR: n.ir_sh = {r.s2[0], r.ir_sh[7:1]};
                default: n.ir_sh = r.ir_sh;
            endcase
        end
        // TDO changes on TCK falling and floats outside the shift states.
        if (fall) begin
            n.tdo_oe_n = 1'b1;
            if (r.st == SHIFT_DR) begin
                n.tdo_oe_n = 1'b0;
                unique case (dr_of(r.ir))
                    DR_ID: n.tdo = r.id_sh[0];
                    DR_BSC: n.tdo = bs_lsb;
                    default: n.tdo = r.byp;
                endcase
            end else if (r.st == SHIFT_IR) begin
                n.tdo_oe_n = 1'b0;
                n.tdo = r.ir_sh[0];
            end
            // Loads come only from the port, whatever the processor does.
            if (r.st == UPD_IR) begin
                n.ir = r.ir_sh;
                if (r.ir_sh[7:4] == `OP_RST_ASSERT) begin
                    n.int_rst = 1'b1;
                end else if (r.ir_sh[7:4] == `OP_RST_NEGATE) begin
                    n.int_rst = 1'b0;
                end
            end
        end
        if (trst_l) begin
            n.st = TLR;
        end
        if (n.st == TLR) begin
            n.ir = `IR_INIT;
        end
        // Write side: address and data are held until both are present.
        if (awvalid && r.awready) begin
            n.aw_ok = 1'b1;
            n.wa = awaddr;
        end
        if (wvalid && r.wready) begin
            n.w_ok = 1'b1;
            n.wd = wdata;
            n.ws = wstrb;
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_ok && r.w_ok && !r.bvalid) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            if (r.wa == `OFF_CTRL) begin
                if (r.ws[0] && r.wd[`CTRL_DBG_CLR]) begin
                    n.dbg_req = 1'b0;
                end
            end else if (r.wa != `OFF_INSTR && r.wa != `OFF_STATUS) begin
                n.bresp = `RESP_DECERR;
            end
        end
        // A debug request load sets the flag after any clear, so it is not lost.
        if (fall && r.st == UPD_IR && r.ir_sh[7:5] == `OP_DEBUG_REQ) begin
            n.dbg_req = 1'b1;
        end
        // Read side: one answer per address, data the cycle after.
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            n.rdata = 32'h0000_0000;
            unique case (araddr)
                `OFF_INSTR: n.rdata = {16'h0000, r.ir, `IR_LOW};
                `OFF_STATUS: n.rdata = {26'h000_0000, r.int_rst, r.dbg_req, r.st};
                `OFF_CTRL: n.rdata = 32'h0000_0000;
                default: n.rresp = `RESP_DECERR;
            endcase
        end
        n.awready = !n.aw_ok && !n.bvalid;
        n.wready = !n.w_ok && !n.bvalid;
        n.arready = !n.rvalid;
        if (reset) begin
            n.st = TLR;
            n.ir = `IR_INIT;
            n.ir_sh = `IR_CAPTURE;
            n.tdo = 1'b0;
            n.tdo_oe_n = 1'b1;
            n.dbg_req = 1'b0;
            n.int_rst = 1'b0;
            n.awready = 1'b0;
            n.wready = 1'b0;
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b0;
            n.bresp = `RESP_OKAY;
            n.arready = 1'b0;
            n.rvalid = 1'b0;
            n.rresp = `RESP_OKAY;
            n.rdata = 32'h0000_0000;
        end
    end

    // Single register of the whole state record.
    always_ff @(posedge clk) begin
        r <= n;
    end

    assign tdo = r.tdo;
    assign tdo_oe_n = r.tdo_oe_n;
    assign debug_req = r.dbg_req;
    assign core_reset_req = r.int_rst;
    assign awready = r.awready;
    assign wready = r.wready;
    assign bresp = r.bresp;
    assign bvalid = r.bvalid;
    assign arready = r.arready;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rvalid = r.rvalid;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_tlr_init;
        r.st == TLR |-> r.ir == `IR_INIT;
    endproperty
    a_tlr_init: assert property (p_tlr_init)
        else $error("instruction not initial in test-logic-reset");

    property p_after_reset;
        $past(reset) |-> r.st == TLR && dr_of(r.ir) == DR_ID;
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("identification not selected after reset");

    property p_bypass_out;
        fall && r.st == SHIFT_DR && dr_of(r.ir) == DR_BYP |=> !r.tdo_oe_n && r.tdo == $past(r.byp);
    endproperty
    a_bypass_out: assert property (p_bypass_out)
        else $error("bypass stage not on the serial output");

    property p_read_instr;
        arvalid && r.arready && araddr == `OFF_INSTR |=> r.rvalid && r.rdata == {16'h0000, $past(r.ir), 8'hFD};
    endproperty
    a_read_instr: assert property (p_read_instr)
        else $error("instruction register read value wrong");

    property p_walk_idle;
        rise && r.st == TLR && !r.s2[1] && r.s2[3] |=> r.st == IDLE;
    endproperty
    a_walk_idle: assert property (p_walk_idle)
        else $error("controller did not leave test-logic-reset");

    property p_ir_load;
        fall && r.st == UPD_IR && r.s2[3] |=> r.ir == $past(r.ir_sh);
    endproperty
    a_ir_load: assert property (p_ir_load)
        else $error("instruction not loaded on update");

    property p_id_capture;
        rise && r.st == CAP_DR && dr_of(r.ir) == DR_ID |=> r.id_sh == ID_VALUE ##1 r.st == SHIFT_DR || r.st == EX1_DR || r.st == TLR;
    endproperty
    a_id_capture: assert property (p_id_capture)
        else $error("identity value not captured");

    property p_tdo_float;
        fall && r.st != SHIFT_DR && r.st != SHIFT_IR |=> r.tdo_oe_n;
    endproperty
    a_tdo_float: assert property (p_tdo_float)
        else $error("serial output driven outside shift");

endmodule: tap_scan

// ===== tb/jtag_tester.sv
// Tester model for the test port: drives TCK, TMS, TDI and TRST_N, reads TDO.
// Assumes the device samples these pins on its own much faster clock.
`timescale 1ns/1ps
module jtag_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    // ********
    // Pin drive
    // ********
    // TCK rests low between frames; the port is held in reset at power-up.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
    end
    // One 48 ns TCK period; TDO is read just before the rising edge.
    // Tasks start on a rising clk edge and every delay is whole clk periods,
    // so pins move by non-blocking assignment and never race the synchroniser.
    task automatic cyc(input logic m, input logic b, output logic q);
        tms <= m;
        tdi <= b;
        #24;
        q = tdo;
        tck <= 1'b1;
        #24;
        tck <= 1'b0;
    endtask: cyc
    // Scan from idle back to idle; TDI shows the inverse of its last bit afterwards.
    task automatic scan(input logic ir, input int n, input logic [332:0] di,
        output logic [332:0] qo);
        logic q;
        qo = '0;
        cyc(1'b0, 1'b0, q);
        cyc(1'b1, 1'b0, q);
        if (ir) cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, di[i], q);
            qo[i] = q;
        end
        cyc(1'b1, ~di[n-1], q);
        cyc(1'b0, ~di[n-1], q);
    endtask: scan
    // Five TMS ones reach test-logic-reset from any state.
    task automatic tlr();
        logic q;
        repeat (5) cyc(1'b1, 1'b0, q);
        #48;
    endtask: tlr
    // Port reset pulse, well beyond the synchroniser delay.
    task automatic prst();
        trst_n <= 1'b0;
        #200;
        trst_n <= 1'b1;
        #48;
    endtask: prst
endmodule: jtag_tester

// ===== tb/tap_scan_test.sv
// Self-checking bench for the test-port registers and their bus view.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
module tap_scan_test;
    localparam logic [31:0] ID = 32'h5A5A_0001; // Arbitrary identity, bit 0 one.
    logic clk, reset, tck, tms, tdi, trst_n, tdo, tdo_oe_n, debug_req, core_reset_req;
    logic [110:0] core_out, core_oe, pad_in, pad_out, pad_oe_n, core_in;
    logic [7:0] awaddr, araddr, c;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [332:0] di, qo;
    logic [3:0] ops [10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF};
    int seed = 78684;
    int mismatches = 0;
    int total_checks = 0;
    tap_scan #(.ID_VALUE(ID)) tap_scan_i (.clk, .reset, .tck, .tms, .tdi, .trst_n, .tdo,
        .tdo_oe_n, .debug_req, .core_reset_req, .core_out, .core_oe, .pad_in, .pad_out,
        .pad_oe_n, .core_in, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);
    jtag_tester jtag_tester_i (.tck, .tms, .tdi, .trst_n, .tdo);
    // ********
    // Helpers
    // ********
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [332:0] rv();
        for (int i = 0; i < 11; i++) rv = {rv[300:0], 32'($random(seed))};
    endfunction: rv
    // Expected bus view of the instruction register.
    function automatic logic [31:0] irw(input logic [7:0] v);
        return {16'h0, v, 8'hFD};
    endfunction: irw
    task automatic chk(input string s, input logic [332:0] e, input logic [332:0] g);
        total_checks++;
        if (e !== g) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", s, e, g);
        end
    endtask: chk
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask: results
    // Bounded wait; the ready or valid seen at a falling edge is sampled at the next rise.
    task automatic wt(input int k);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((k == 0 ? arready : k == 1 ? rvalid : bvalid) !== 1'b1 && n < 300);
        if (n >= 300) begin
            mismatches++;
            results();
        end
    endtask: wt
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wt(0);
        @(posedge clk);
        arvalid <= 1'b0;
        wt(1);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask: rd
    // Address and data are released each on its own ready.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (300) if (pa || pw) begin
            @(negedge clk);
            if (awready === 1'b1) pa = 1'b0;
            if (wready === 1'b1) pw = 1'b0;
            @(posedge clk);
            if (!pa) awvalid <= 1'b0;
            if (!pw) wvalid <= 1'b0;
        end
        if (pa || pw) begin
            mismatches++;
            results();
        end
        wt(2);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask: wr
    task automatic ld(input logic [7:0] v);
        jtag_tester_i.scan(1'b1, 8, {325'h0, v}, qo);
        chk("ir_capture", 8'h01, qo[7:0]);
    endtask: ld
    // ********
    // Sequence
    // ********
    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        di = rv();
        core_out = di[110:0];
        core_oe = di[221:111];
        pad_in = di[332:222];
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        jtag_tester_i.prst();
        rd(8'h00);
        chk("instr", irw(8'hEF), d);
        wr(8'h00, 32'($random(seed)));
        chk("bresp", 2'h0, r);
        wr(8'h14, 32'h0);
        chk("bresp_unmapped", 2'h3, r);
        rd(8'h00);
        chk("instr_ro", irw(8'hEF), d);
        chk("rresp", 2'h0, r);
        rd(8'h10);
        chk("unmapped", 2'h3, r);
        jtag_tester_i.scan(1'b0, 32, rv(), qo);
        chk("ident", ID, qo[31:0]);
        $display("test registers done");
        // Every command; low bits random, never a reserved code.
        foreach (ops[i]) begin
            c = {ops[i], 4'($random(seed))};
            ld(c);
            rd(8'h00);
            chk("instr", irw(c), d);
        end
        di = rv();
        jtag_tester_i.scan(1'b0, 40, di, qo);
        chk("bypass", di[38:0], qo[39:1]);
        chk("tdo_float", 1, tdo_oe_n);
        ld(8'h7C);
        chk("core_rst", 1, core_reset_req);
        ld(8'h65);
        chk("core_rst", 0, core_reset_req);
        ld(8'hA9);
        chk("dbg_req", 1, debug_req);
        wr(8'h04, 32'h1);
        chk("dbg_req", 0, debug_req);
        $display("test commands done");
        ld(8'h4F);
        di = rv();
        jtag_tester_i.scan(1'b0, 333, di, qo);
        chk("sample", pad_in, qo[332:222]);
        chk("sample_out", core_out, qo[221:111]);
        chk("sample_ctl", core_oe, qo[110:0]);
        ld(8'h0F);
        chk("pad_out", di[221:111], pad_out);
        chk("pad_oe_n", {~di[110:0]}, pad_oe_n);
        chk("core_in", di[332:222], core_in);
        ld(8'h3F);
        chk("highz", {111{1'b1}}, pad_oe_n);
        ld(8'h2F);
        chk("clamp", di[221:111], pad_out);
        jtag_tester_i.scan(1'b0, 2, di, qo);
        chk("clamp_byp", di[0], qo[1]);
        $display("test boundary done");
        jtag_tester_i.tlr();
        rd(8'h00);
        chk("instr", irw(8'hEF), d);
        rd(8'h08);
        chk("state", 6'h00, d[5:0]);
        ld(8'hFF);
        jtag_tester_i.prst();
        rd(8'h00);
        chk("instr", irw(8'hEF), d);
        chk("pad_func", core_out, pad_out);
        chk("pad_oe_func", {~core_oe}, pad_oe_n);
        chk("core_in_func", pad_in, core_in);
        $display("test resets done");
        results();
    end
endmodule: tap_scan_test
